// >>> mtc_tx.v
// transmit configuration registers, frame padder with gap timer, and statistics counters
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`include "mtc_defines.vh"
module mtc_tx #(
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire [11:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [7:0]  src_data,
	input  wire        src_last,
	input  wire        src_valid,
	output wire        src_ready,
	output reg  [7:0]  tx_data,
	output reg         tx_valid,
	output reg         tx_last,
	input  wire        tx_ready,
	input  wire        half_duplex,
	input  wire        tx_deferred,
	input  wire        tx_pause_sent,
	input  wire        tx_ok,
	input  wire        rx_ok,
	output reg         backoff_clear,
	output reg  [15:0] pause_time,
	output reg         counter_test_mode,
	output wire [7:0]  ifg_bit_times
);
	localparam ST_DATA = 2'd0;
	localparam ST_PAD  = 2'd1;
	localparam ST_FCS  = 2'd2;
	localparam ST_GAP  = 2'd3;

	reg        tx_enable;
	reg        pad_enable;
	reg [4:0]  interframe_gap_setting;
	reg [1:0]  backoff_mode;
	reg [31:0] tx_deferred_frame_count;
	reg [31:0] tx_pause_frame_count;
	reg        rd_done;
	reg [1:0]  state;
	reg [6:0]  byte_cnt;
	reg [1:0]  fcs_cnt;
	reg [7:0]  gap_cnt;
	reg [31:0] crc;
	reg [31:0] next_crc;
	reg [7:0]  crc_in;
	integer    i;

	wire [8:0] f_data;
	wire       f_valid;
	wire       f_ready;
	wire       rd_defer = avs_read & ~rd_done & (avs_address == `MTC_IDX_DEFER);
	wire       rd_pause = avs_read & ~rd_done & (avs_address == `MTC_IDX_PAUSE);
	wire       wr_take  = avs_write & ~avs_waitrequest;
	wire       out_go   = ~tx_valid | tx_ready;

	// reads take one wait cycle so data comes from a flop; writes are immediate
	assign avs_waitrequest = avs_read & ~rd_done;
	assign ifg_bit_times = {1'b0, interframe_gap_setting, 2'b00} + `MTC_IFG_ADD;

	mtc_fifo #(
		.WIDTH (9),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_data   ({src_last, src_data}),
		.in_valid  (src_valid),
		.in_ready  (src_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	// fifo drains only in data state while enabled and output free
	assign f_ready = (state == ST_DATA) & tx_enable & out_go;

	always @*
	begin
		next_crc = crc;
		crc_in = (state == ST_DATA) ? f_data[7:0] : 8'h00;
		for (i = 0; i < 8; i = i + 1)
			next_crc = (next_crc[0] ^ crc_in[i]) ? ((next_crc >> 1) ^ 32'hedb8_8320) : (next_crc >> 1);
	end

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_enable              <= 1'b1;
			pad_enable             <= 1'b1;
			interframe_gap_setting <= `MTC_RST_IFG;
			counter_test_mode      <= 1'b0;
			backoff_mode           <= `MTC_RST_BO;
			pause_time             <= `MTC_RST_PAUSE;
		end
		else if (wr_take)
		begin
			if (avs_address == `MTC_IDX_CFG)
			begin
				tx_enable              <= avs_writedata[`MTC_CFG_EN_BIT];
				pad_enable             <= avs_writedata[`MTC_CFG_PAD_BIT];
				interframe_gap_setting <= avs_writedata[`MTC_CFG_IFG_MSB:`MTC_CFG_IFG_LSB];
				counter_test_mode      <= avs_writedata[`MTC_CFG_TEST_BIT];
			end
			if (avs_address == `MTC_IDX_FC)
			begin
				backoff_mode <= avs_writedata[`MTC_FC_BO_MSB:`MTC_FC_BO_LSB];
				pause_time   <= avs_writedata[`MTC_FC_PT_MSB:0];
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_done      <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			rd_done <= avs_read & ~rd_done;
			if (avs_read & ~rd_done)
			begin
				case (avs_address)
				`MTC_IDX_CFG:   avs_readdata <= {24'h0000_00, counter_test_mode, interframe_gap_setting,
				                                  pad_enable, tx_enable};
				`MTC_IDX_FC:    avs_readdata <= {14'h0000, backoff_mode, pause_time};
				`MTC_IDX_DEFER: avs_readdata <= tx_deferred_frame_count;
				`MTC_IDX_PAUSE: avs_readdata <= tx_pause_frame_count;
				default:        avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// counters: an event in the read cycle is kept, counting from zero or the test value
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_deferred_frame_count <= 32'h0000_0000;
			tx_pause_frame_count    <= 32'h0000_0000;
		end
		else
		begin
			// not a byte-length counter, so test mode loads the plain test value
			if (rd_defer)
				tx_deferred_frame_count <= (counter_test_mode ? `MTC_TEST_VAL : 32'h0000_0000)
				                           + {31'h000_0000, tx_deferred & half_duplex};
			else if (tx_deferred & half_duplex & (tx_deferred_frame_count != `MTC_CNT_MAX))
				tx_deferred_frame_count <= tx_deferred_frame_count + 1'b1;
			if (rd_pause)
				tx_pause_frame_count <= (counter_test_mode ? `MTC_TEST_VAL : 32'h0000_0000)
				                        + {31'h000_0000, tx_pause_sent};
			else if (tx_pause_sent & (tx_pause_frame_count != `MTC_CNT_MAX))
				tx_pause_frame_count <= tx_pause_frame_count + 1'b1;
		end
	end

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			backoff_clear <= 1'b0;
		else
			backoff_clear <= half_duplex & (backoff_mode[1] ? (tx_ok | rx_ok) :
			                 (backoff_mode[0] ? rx_ok : tx_ok));
	end

	// frame path: data, then zero pad to 60 and fcs only while padding is enabled, then gap
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state    <= ST_DATA;
			byte_cnt <= 7'd0;
			fcs_cnt  <= 2'd0;
			gap_cnt  <= 8'd0;
			crc      <= 32'hffff_ffff;
			tx_data  <= 8'h00;
			tx_valid <= 1'b0;
			tx_last  <= 1'b0;
		end
		else
		begin
			if (tx_ready)
				tx_valid <= 1'b0;
			case (state)
			ST_DATA:
			begin
				if (f_valid & f_ready)
				begin
					tx_data  <= f_data[7:0];
					tx_valid <= 1'b1;
					tx_last  <= 1'b0;
					crc      <= next_crc;
					byte_cnt <= (byte_cnt == 7'd127) ? byte_cnt : byte_cnt + 1'b1;
					if (f_data[8])
						state <= (pad_enable & (byte_cnt < `MTC_MIN_DATA - 7'h01)) ? ST_PAD :
						         (pad_enable ? ST_FCS : ST_GAP);
					if (f_data[8] & ~pad_enable)
					begin
						tx_last <= 1'b1;
						gap_cnt <= ifg_bit_times >> 3;
						byte_cnt <= 7'd0;
						crc <= 32'hffff_ffff;
					end
				end
			end
			ST_PAD:
			begin
				if (out_go)
				begin
					tx_data  <= 8'h00;
					tx_valid <= 1'b1;
					tx_last  <= 1'b0;
					crc      <= next_crc;
					byte_cnt <= byte_cnt + 1'b1;
					if (byte_cnt + 1'b1 == `MTC_MIN_DATA)
						state <= ST_FCS;
				end
			end
			ST_FCS:
			begin
				if (out_go)
				begin
					tx_data  <= ~crc[7:0];
					tx_valid <= 1'b1;
					crc      <= {8'hff, crc[31:8]};
					fcs_cnt  <= fcs_cnt + 1'b1;
					tx_last  <= (fcs_cnt == 2'd3);
					if (fcs_cnt == 2'd3)
					begin
						state    <= ST_GAP;
						byte_cnt <= 7'd0;
						crc      <= 32'hffff_ffff;
						gap_cnt  <= ifg_bit_times >> 3;
					end
				end
			end
			ST_GAP:
			begin
				// gap counted in byte slots after the last byte is taken
				if (~tx_valid | tx_ready)
				begin
					if (gap_cnt == 8'd0)
						state <= ST_DATA;
					else
						gap_cnt <= gap_cnt - 1'b1;
				end
			end
			default:
				state <= ST_DATA;
			endcase
		end
	end
endmodule

// >>> mtc_defines.vh
// constants for the transmit configuration and counter block
// Behaviour
// - in counter test mode, clear-on-read counters load 7FFF_FFFC on read
// - in test mode, the byte-length counters load 7FFF_FF80 on read instead
// - inter-frame gap in bit times is four times the setting plus twelve
// - padding enabled by default: short frames zero-padded and given an FCS
// - with padding, frames of sixty bytes or fewer leave as sixty-four bytes
// - with padding, 61 to 63 byte frames get only the FCS, becoming 65 to 67
// - transmitter takes frame data only while transmit enable is set, but pad and FCS already started still go out; resets to one
// - backoff reset field acts only in half duplex
// - backoff reset: 00 after transmit, 01 after receive, 1X after either
// - transmitted pause frames carry the programmed pause time, reset all ones
// - deferral counter counts deferred first attempts, not collisions
// - deferral counter increments only in half duplex
// - pause counter increments once per transmitted pause frame
// - reading a counter returns its value and clears it, unless test mode
// - counters saturate at all ones instead of wrapping
`ifndef MTC_DEFINES_VH
`define MTC_DEFINES_VH
`define MTC_IDX_CFG        12'h440
`define MTC_IDX_FC         12'h441
`define MTC_IDX_DEFER      12'h451
`define MTC_IDX_PAUSE      12'h452
`define MTC_CFG_EN_BIT     0
`define MTC_CFG_PAD_BIT    1
`define MTC_CFG_IFG_LSB    2
`define MTC_CFG_IFG_MSB    6
`define MTC_CFG_TEST_BIT   7
`define MTC_FC_PT_MSB      15
`define MTC_FC_BO_LSB      16
`define MTC_FC_BO_MSB      17
`define MTC_RST_IFG        5'h15
`define MTC_RST_PAUSE      16'hffff
`define MTC_RST_BO         2'h0
`define MTC_TEST_VAL       32'h7fff_fffc
`define MTC_TEST_LEN_VAL   32'h7fff_ff80
`define MTC_CNT_MAX        32'hffff_ffff
`define MTC_IFG_MUL        4
`define MTC_IFG_ADD        8'h0c
`define MTC_MIN_DATA       7'd60
`define MTC_MIN_FRAME      7'd64
`define MTC_FCS_LEN        3'd4
`endif

// >>> mtc_fifo.v
// first-word-fall-through fifo for the transmit byte stream
`timescale 1ns/10ps
module mtc_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             sys_clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      fill;
	wire            push;
	wire            pop;

	assign in_ready  = (fill != DEPTH[AW:0]);
	assign out_valid = (fill != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			fill   <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push & ~pop)
				fill <= fill + 1'b1;
			else if (pop & ~push)
				fill <= fill - 1'b1;
		end
	end
endmodule

// >>> mtc_tx_props.sv
// port checker for the transmit config block
`timescale 1ns/10ps
`include "mtc_defines.vh"
module mtc_tx_props (
	input wire        sys_clk,
	input wire        rst_n,
	input wire [11:0] avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire [7:0]  tx_data,
	input wire        tx_valid,
	input wire        tx_last,
	input wire        tx_ready,
	input wire        half_duplex,
	input wire        backoff_clear,
	input wire [15:0] pause_time,
	input wire        counter_test_mode,
	input wire [7:0]  ifg_bit_times
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	reg       pad;
	reg [6:0] cnt;
	wire      wcfg = avs_write && avs_address == `MTC_IDX_CFG;
	wire      wfc  = avs_write && avs_address == `MTC_IDX_FC;
	wire      beat = tx_valid && tx_ready;
	// pad flag shadow and byte count of the frame on the wire
	always @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			pad <= 1'b1;
			cnt <= 7'h00;
		end
		else
		begin
			if (wcfg)
				pad <= avs_writedata[1];
			if (beat)
				cnt <= tx_last ? 7'h00 : cnt + {6'h00, cnt != 7'h7f};
		end
	sequence s_rd_first;
		avs_read && avs_waitrequest;
	endsequence
	sequence s_rd_done;
		avs_read && !avs_waitrequest;
	endsequence
	a_rd_one_wait: assert property ($rose(avs_read) |-> s_rd_first ##1 s_rd_done)
		else $error("read wait not one cycle");
	a_wr_no_wait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write waited");
	a_cfg_rsv_zero: assert property (s_rd_done ##0 avs_address == `MTC_IDX_CFG |-> avs_readdata[31:8] == 24'h00_0000)
		else $error("reserved bits not zero");
	a_pause_follow: assert property (wfc |=> pause_time == $past(avs_writedata[15:0]))
		else $error("pause time mismatch");
	a_test_follow: assert property (wcfg |=> counter_test_mode == $past(avs_writedata[7]))
		else $error("test mode mismatch");
	a_ifg_calc: assert property (wcfg |=> ifg_bit_times == $past(avs_writedata[6:2]) * 4 + 12)
		else $error("gap mismatch");
	a_bo_full_dup: assert property (!half_duplex |=> !backoff_clear)
		else $error("backoff clear in full duplex");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("tx byte dropped");
	a_pad_min: assert property (beat && tx_last && pad |-> cnt >= 7'h3f)
		else $error("padded frame short");
endmodule
bind mtc_tx mtc_tx_props u_props (
	.sys_clk           (sys_clk),
	.rst_n             (rst_n),
	.avs_address       (avs_address),
	.avs_read          (avs_read),
	.avs_write         (avs_write),
	.avs_writedata     (avs_writedata),
	.avs_readdata      (avs_readdata),
	.avs_waitrequest   (avs_waitrequest),
	.tx_data           (tx_data),
	.tx_valid          (tx_valid),
	.tx_last           (tx_last),
	.tx_ready          (tx_ready),
	.half_duplex       (half_duplex),
	.backoff_clear     (backoff_clear),
	.pause_time        (pause_time),
	.counter_test_mode (counter_test_mode),
	.ifg_bit_times     (ifg_bit_times)
);

// >>> mtc_phy_sink.sv
// link-side byte sink with optional stalling
`timescale 1ns/10ps
module mtc_phy_sink (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire [7:0]  tx_data,
	input  wire        tx_valid,
	input  wire        tx_last,
	input  wire        slow,
	output reg         tx_ready,
	output reg  [7:0]  frame_len,
	output reg         frame_done,
	output reg  [31:0] frame_crc
);
	integer    seed = 32'ha31a_73ad;
	integer    rnd;
	integer    b;
	reg [7:0]  cnt;
	reg [31:0] crc;
	reg [31:0] c;
	// running crc over every byte on the wire, fcs included
	always @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			tx_ready   <= 1'b0;
			cnt        <= 8'h00;
			frame_len  <= 8'h00;
			frame_done <= 1'b0;
			crc        <= 32'hffff_ffff;
			frame_crc  <= 32'h0000_0000;
		end
		else
		begin
			rnd = $random(seed);
			tx_ready   <= !slow || rnd[0];
			frame_done <= tx_valid && tx_ready && tx_last;
			if (tx_valid && tx_ready)
			begin
				c = crc;
				for (b = 0; b < 8; b = b + 1)
					c = (c[0] ^ tx_data[b]) ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
				cnt       <= tx_last ? 8'h00 : cnt + 8'h01;
				frame_len <= cnt + 8'h01;
				crc       <= tx_last ? 32'hffff_ffff : c;
				frame_crc <= c;
			end
		end
endmodule

// >>> mtc_tx_tb.sv
// self-checking bench for the transmit config block
`timescale 1ns/10ps
`include "mtc_defines.vh"
module mtc_tx_tb;
	reg          sys_clk = 0;
	reg          rst_n = 0;
	reg  [11:0]  avs_address = 0;
	reg          avs_read = 0;
	reg          avs_write = 0;
	reg  [31:0]  avs_writedata = 0;
	reg  [7:0]   src_data = 0;
	reg          src_last = 0;
	reg          src_valid = 0;
	reg          half_duplex = 0;
	reg          tx_deferred = 0;
	reg          tx_pause_sent = 0;
	reg          tx_ok = 0;
	reg          rx_ok = 0;
	reg          slow = 0;
	wire [31:0]  avs_readdata;
	wire         avs_waitrequest;
	wire         src_ready;
	wire [7:0]   tx_data;
	wire         tx_valid;
	wire         tx_last;
	wire         tx_ready;
	wire         backoff_clear;
	wire [15:0]  pause_time;
	wire         counter_test_mode;
	wire [7:0]   ifg_bit_times;
	wire [7:0]   frame_len;
	wire         frame_done;
	wire [31:0]  frame_crc;
	integer      num_errors = 0;
	integer      checked = 0;
	integer      seed = 32'ha31a_73ad;
	integer      cyc = 0;
	integer      acc = 0;
	integer      tn = 0;
	integer      i;
	integer      n;
	logic [31:0] rd_q[$];
	logic [31:0] len_q[$];
	logic        fcs_q[$];
	always #10 sys_clk = ~sys_clk;
	mtc_tx dut (
		.sys_clk           (sys_clk),
		.rst_n             (rst_n),
		.avs_address       (avs_address),
		.avs_read          (avs_read),
		.avs_write         (avs_write),
		.avs_writedata     (avs_writedata),
		.avs_readdata      (avs_readdata),
		.avs_waitrequest   (avs_waitrequest),
		.src_data          (src_data),
		.src_last          (src_last),
		.src_valid         (src_valid),
		.src_ready         (src_ready),
		.tx_data           (tx_data),
		.tx_valid          (tx_valid),
		.tx_last           (tx_last),
		.tx_ready          (tx_ready),
		.half_duplex       (half_duplex),
		.tx_deferred       (tx_deferred),
		.tx_pause_sent     (tx_pause_sent),
		.tx_ok             (tx_ok),
		.rx_ok             (rx_ok),
		.backoff_clear     (backoff_clear),
		.pause_time        (pause_time),
		.counter_test_mode (counter_test_mode),
		.ifg_bit_times     (ifg_bit_times)
	);
	mtc_phy_sink u_sink (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.tx_data    (tx_data),
		.tx_valid   (tx_valid),
		.tx_last    (tx_last),
		.slow       (slow),
		.tx_ready   (tx_ready),
		.frame_len  (frame_len),
		.frame_done (frame_done),
		.frame_crc  (frame_crc)
	);
	task check(input [31:0] got, input [31:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task tdone;
		tn = tn + 1;
		$display("test %0d done", tn);
	endtask
	task wr(input [11:0] a, input [31:0] d);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest);
		avs_write <= 1'b0;
	endtask
	task rd(input [11:0] a, input [31:0] e);
		rd_q.push_back(e);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest);
		avs_read <= 1'b0;
	endtask
	task ev(input [3:0] m, input exp);
		@(posedge sys_clk);
		{tx_deferred, tx_pause_sent, tx_ok, rx_ok} <= m;
		@(posedge sys_clk);
		{tx_deferred, tx_pause_sent, tx_ok, rx_ok} <= 4'h0;
		@(posedge sys_clk);
		check(backoff_clear, exp);
	endtask
	task send(input integer len, input integer exp);
		integer k;
		len_q.push_back(exp);
		fcs_q.push_back(exp != len);
		@(posedge sys_clk);
		for (k = 0; k < len; k = k + 1)
		begin
			src_data  <= 8'($random(seed));
			src_last  <= k == len - 1;
			src_valid <= 1'b1;
			do @(posedge sys_clk); while (!src_ready);
		end
		src_valid <= 1'b0;
	endtask
	// results are compared as they appear
	always @(posedge sys_clk)
	begin
		if (avs_read && !avs_waitrequest)
			check(avs_readdata, rd_q.pop_front());
		if (frame_done)
		begin
			check({24'h00_0000, frame_len}, len_q.pop_front());
			if (fcs_q.pop_front())
				check(frame_crc, 32'hdebb_20e3);
		end
		if (src_valid && src_ready)
			acc = acc + 1;
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			num_errors = num_errors + 1;
			finish_test;
		end
	end
	initial
	begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`MTC_IDX_CFG, 32'h0000_0057);
		rd(`MTC_IDX_FC, 32'h0000_ffff);
		rd(`MTC_IDX_DEFER, 32'h0000_0000);
		rd(`MTC_IDX_PAUSE, 32'h0000_0000);
		rd(12'h443, 32'h0000_0000);
		check(ifg_bit_times, 32'h0000_0060);
		wr(`MTC_IDX_CFG, 32'hffff_ff3f);
		wr(`MTC_IDX_FC, 32'hfffe_1234);
		rd(`MTC_IDX_CFG, 32'h0000_003f);
		rd(`MTC_IDX_FC, 32'h0002_1234);
		check(ifg_bit_times, 32'h0000_0048);
		check(pause_time, 32'h0000_1234);
		tdone;
		half_duplex <= 1'b1;
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(`MTC_IDX_FC, {14'h0000, i[1:0], 16'hffff});
			ev(4'h2, i != 1);
			ev(4'h1, i != 0);
		end
		half_duplex <= 1'b0;
		ev(4'h3, 1'b0);
		repeat (2) ev(4'hc, 1'b0);
		half_duplex <= 1'b1;
		repeat (3) ev(4'hc, 1'b0);
		rd(`MTC_IDX_DEFER, 32'h0000_0003);
		rd(`MTC_IDX_PAUSE, 32'h0000_0005);
		rd(`MTC_IDX_DEFER, 32'h0000_0000);
		wr(`MTC_IDX_CFG, 32'h0000_00bf);
		rd(`MTC_IDX_DEFER, 32'h0000_0000);
		rd(`MTC_IDX_DEFER, 32'h7fff_fffc);
		wr(`MTC_IDX_CFG, 32'h0000_003f);
		rd(`MTC_IDX_DEFER, 32'h7fff_fffc);
		rd(`MTC_IDX_DEFER, 32'h0000_0000);
		tdone;
		for (i = 0; i < 6; i = i + 1)
		begin
			n = i == 0 ? 1 : i == 1 ? 60 : i == 2 ? 61 : i == 3 ? 63 : 1 + {$random(seed)} % 100;
			slow <= i[0];
			send(n, n < 61 ? 64 : n + 4);
		end
		while (len_q.size() != 0) @(posedge sys_clk);
		wr(`MTC_IDX_CFG, 32'h0000_003e);
		acc = 0;
		fork
			send(40, 64);
		join_none
		repeat (60) @(posedge sys_clk);
		check(acc, 32'h0000_0020);
		slow <= 1'b1;
		wr(`MTC_IDX_CFG, 32'h0000_003f);
		while (len_q.size() != 0) @(posedge sys_clk);
		wr(`MTC_IDX_CFG, 32'h0000_003d);
		send(10, 10);
		while (len_q.size() != 0) @(posedge sys_clk);
		tdone;
		finish_test;
	end
endmodule
